// >>> rtl/lse_pkg.sv
// Shared constants, encodings and carrier types of the sequence engine
package lse_pkg;
  localparam int          CLK_HZ      = 100_000_000;
  localparam int          BASE_HZ     = 32768;
  localparam logic [11:0] TB_DIV      = 12'(CLK_HZ / BASE_HZ);
  localparam logic [14:0] INSTR_TICKS = 15'h0010;
  localparam logic [14:0] PRE0_DIV    = 15'h0010;
  localparam logic [14:0] PRE1_DIV    = 15'h0200;
  localparam logic [1:0]  TRIG_OUT_TK = 2'h3;
  localparam logic [1:0]  TRIG_IN_TK  = 2'h2;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_ENABLE  = 8'h00;
  localparam logic [7:0]  IDX_CONFIG  = 8'h08;
  localparam logic [7:0]  IDX_PC0     = 8'h09;
  localparam logic [7:0]  IDX_STATUS  = 8'h0C;
  localparam logic [7:0]  IDX_PROG    = 8'h70;
  localparam logic [7:0]  IDX_PWM     = 8'h71;
  localparam int          EN_LOG_BIT  = 7;
  localparam int          CFG_INT_BIT = 0;
  localparam int          CFG_DET_BIT = 1;
  localparam int          PROG_CH_LSB = 20;
  localparam int          PROG_AD_LSB = 16;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  RUN_HOLD    = 2'h0;
  localparam logic [1:0]  RUN_STEP    = 2'h1;
  localparam logic [1:0]  RUN_GO      = 2'h2;
  localparam logic [1:0]  RUN_ONCE    = 2'h3;

  typedef enum logic [2:0] {
    S_HOLD  = 3'h0,
    S_FHI   = 3'h1,
    S_FLO   = 3'h3,
    S_EXE   = 3'h2,
    S_TIME  = 3'h6,
    S_TWAIT = 3'h7
  } lse_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [9:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [9:0]  araddr;
    logic        rready;
  } lse_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } lse_axi_rsp_t;

  typedef struct packed {
    lse_state_t        st;
    logic [3:0]        pc;
    logic [15:0]       ins;
    logic [14:0]       cnt;
    logic [7:0]        steps;
    logic [7:0]        pwm;
    logic [1:0]        run;
    logic [3:0]        lat;
    logic [15:0][5:0]  lpc;
    logic [15:0][15:0] mem;
  } lse_ch_t;

  typedef struct packed {
    lse_ch_t [2:0]   ch;
    lse_axi_rsp_t    rsp;
    logic            aw_have;
    logic            w_have;
    logic [9:0]      awaddr;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            log_en;
    logic            int_clk_en;
    logic            det_en;
    logic [2:0]      status;
    logic            int_n;
    logic [11:0]     tdiv;
    logic            ext_prev;
    logic [1:0]      tin_cnt;
    logic [1:0]      tout_cnt;
    logic            trig_oe;
    logic            trig_lvl;
    logic [7:0]      pcnt;
    logic [2:0][7:0] duty;
    logic [2:0]      led_on;
  } lse_top_t;
endpackage : lse_pkg

// >>> rtl/lse_engine.sv
// Three-channel LED sequence engine with AXI4-Lite register access
// Operation
// RQ1: all instruction timing runs from a 32768 Hz base tick
// RQ2: config bits choose internal or external base clock
// RQ3: ramp fields: prescale, six-bit step time, sign, seven-bit increment
// RQ4: prescale 0 divides base by 16, prescale 1 by 512
// RQ5: step lasts step time times tick; step time zero means set PWM
// RQ6: ramp starts at current PWM, one count per step
// RQ7: increment plus one steps; increment zero is a pure wait
// RQ8: PWM saturates at 0 or 255, remaining time still spent
// RQ9: log enable bit selects logarithmic or linear brightness curve
// RQ10: set PWM loads bits 7:0 and takes sixteen base cycles
// RQ11: all-zero word jumps to location 0, sixteen base cycles
// RQ12: program memory resets to zero, i.e. go to start
// RQ13: branch loads step number into PC, sixteen base cycles
// RQ14: branch is 101 with loop count 12:7 and target 3:0
// RQ15: branch repeats loop count times; zero loops forever
// RQ16: every branch keeps its own loop counter, unlimited nesting
// RQ17: end stops channel, clears PC, run field to hold
// RQ18: three independent channels sharing one trigger fabric
// RQ19: brightness is an 8-bit PWM value, 256 levels
// RQ20: trigger is 111, wait mask 12:7, send mask 6:1
// RQ21: end with int sets status and pulls interrupt low; reset zeroes PWM
// RQ22: triggers latched; wait stalls until all masked arrive, then clears
// RQ23: PC wraps from 15 to 0
// RQ24: exhausted loop counter reloads when branch falls through
// RQ25: instruction fetched as two bytes, high first, then decoded
`timescale 1ns/1ps
module lse_engine (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire lse_pkg::lse_axi_req_t axi_req,
  output lse_pkg::lse_axi_rsp_t      axi_rsp,
  input  wire logic                  ext_timebase_input,
  input  wire logic                  trig_in_n,
  output logic                       trig_out_n,
  output logic                       trig_oe,
  output logic                       int_n,
  output logic [2:0][7:0]            led_duty,
  output logic [2:0]                 led_on
);
  lse_pkg::lse_top_t r;
  lse_pkg::lse_top_t n;

  ////////////////////////////////////////////////////////////////////////////
  // RQ4: prescale divider
  function automatic logic [14:0] step_period(input logic [15:0] i);
    step_period = 15'(i[13:8] * (i[14] ? lse_pkg::PRE1_DIV
                                       : lse_pkg::PRE0_DIV));
  endfunction : step_period

  // Squared curve stands in for a log table; cheap and monotonic
  function automatic logic [7:0] curve(input logic [7:0] p,
                                       input logic       lg);
    logic [16:0] sq;
    sq = 17'(p * p) + 17'h000FF;
    curve = lg ? sq[15:8] : p;
  endfunction : curve

  function automatic logic is_ramp(input logic [15:0] i);
    is_ramp = !i[15] && (i[13:8] != 6'h00);
  endfunction : is_ramp

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic            tick;
    logic            ext_evt;
    logic [2:0][3:0] snd;
    logic [2:0]      st_set;
    logic [2:0]      st_clr;
    logic [15:0]     ins;
    logic [3:0]      seq_pc;
    logic [3:0]      wm;
    logic [5:0]      lc;
    logic [1:0]      wch;
    logic [7:0]      idx;
    logic            done;
    tick    = 1'b0;
    ext_evt = 1'b0;
    snd     = '0;
    st_set  = '0;
    st_clr  = '0;
    ins     = '0;
    seq_pc  = '0;
    wm      = '0;
    lc      = '0;
    wch     = '0;
    idx     = '0;
    done    = 1'b0;
    n       = r;

    // RQ2: clock select
    if (!r.int_clk_en && r.det_en) begin
      tick = ext_timebase_input && !r.ext_prev;
    end else begin
      // RQ1: internal base tick
      tick = (r.tdiv == 12'h000);
    end
    n.ext_prev = ext_timebase_input;
    n.tdiv = (r.tdiv == 12'h000) ? 12'(lse_pkg::TB_DIV - 12'h001)
                                 : 12'(r.tdiv - 12'h001);

    // Own pulse is masked so a sender never sees its own trigger
    if (tick) begin
      if (!trig_in_n && !r.trig_oe) begin
        if (r.tin_cnt != lse_pkg::TRIG_IN_TK) begin
          n.tin_cnt = 2'(r.tin_cnt + 2'h1);
        end
        ext_evt = (r.tin_cnt == 2'(lse_pkg::TRIG_IN_TK - 2'h1));
      end else begin
        n.tin_cnt = 2'h0;
      end
    end
    if (tick && r.tout_cnt != 2'h0) begin
      n.tout_cnt = 2'(r.tout_cnt - 2'h1);
    end

    // RQ20: send masks, bit 3 is the external pin
    for (int s = 0; s < 3; s++) begin
      if (r.ch[s].st == lse_pkg::S_EXE && r.ch[s].ins[15:13] == 3'h7) begin
        snd[s] = {r.ch[s].ins[6], r.ch[s].ins[3:1]};
      end
    end
    if (snd[0][3] || snd[1][3] || snd[2][3]) begin
      n.tout_cnt = lse_pkg::TRIG_OUT_TK;
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    if (axi_req.awvalid && r.rsp.awready) begin
      n.aw_have = 1'b1;
      n.awaddr  = axi_req.awaddr;
    end
    if (axi_req.wvalid && r.rsp.wready) begin
      n.w_have = 1'b1;
      n.wdata  = axi_req.wdata;
      n.wstrb  = axi_req.wstrb;
    end
    if (r.rsp.bvalid && axi_req.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (r.aw_have && r.w_have) begin
      n.aw_have     = 1'b0;
      n.w_have      = 1'b0;
      n.rsp.bvalid  = 1'b1;
      n.rsp.bresp   = lse_pkg::RESP_OKAY;
      idx = r.awaddr[9:2];
      if (idx == lse_pkg::IDX_ENABLE) begin
        if (r.wstrb[0]) begin
          n.log_en = r.wdata[lse_pkg::EN_LOG_BIT];
          for (int c = 0; c < 3; c++) begin
            n.ch[c].run = r.wdata[5 - 2 * c -: 2];
          end
        end
      end else if (idx == lse_pkg::IDX_CONFIG) begin
        if (r.wstrb[0]) begin
          n.int_clk_en = r.wdata[lse_pkg::CFG_INT_BIT];
          n.det_en     = r.wdata[lse_pkg::CFG_DET_BIT];
        end
      end else if (idx >= lse_pkg::IDX_PC0 &&
                   idx < lse_pkg::IDX_STATUS) begin
        wch = 2'(idx - lse_pkg::IDX_PC0);
        // PC is only writable while its channel is stopped
        if (r.wstrb[0] && r.ch[wch].st == lse_pkg::S_HOLD) begin
          n.ch[wch].pc = r.wdata[3:0];
        end
      end else if (idx == lse_pkg::IDX_STATUS) begin
        n.rsp.bresp = lse_pkg::RESP_OKAY;
      end else if (idx == lse_pkg::IDX_PROG) begin
        wch = r.wdata[lse_pkg::PROG_CH_LSB +: 2];
        if (r.wstrb[2:0] == 3'h7 && wch != 2'h3 &&
            r.ch[wch].st == lse_pkg::S_HOLD) begin
          n.ch[wch].mem[r.wdata[lse_pkg::PROG_AD_LSB +: 4]] =
            r.wdata[15:0];
        end
      end else begin
        n.rsp.bresp = lse_pkg::RESP_SLVERR;
      end
    end
    n.rsp.awready = !n.aw_have && !n.rsp.bvalid;
    n.rsp.wready  = !n.w_have && !n.rsp.bvalid;

    if (r.rsp.rvalid && axi_req.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && r.rsp.arready) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp  = lse_pkg::RESP_OKAY;
      n.rsp.rdata  = 32'h00000000;
      idx = axi_req.araddr[9:2];
      if (idx == lse_pkg::IDX_ENABLE) begin
        n.rsp.rdata[7:0] = {r.log_en, 1'b0, r.ch[0].run, r.ch[1].run,
                            r.ch[2].run};
      end else if (idx == lse_pkg::IDX_CONFIG) begin
        n.rsp.rdata[1:0] = {r.det_en, r.int_clk_en};
      end else if (idx >= lse_pkg::IDX_PC0 &&
                   idx < lse_pkg::IDX_STATUS) begin
        n.rsp.rdata[3:0] = r.ch[2'(idx - lse_pkg::IDX_PC0)].pc;
      end else if (idx == lse_pkg::IDX_STATUS) begin
        n.rsp.rdata[2:0] = r.status;
        // RQ21: read clears
        st_clr = 3'h7;
      end else if (idx == lse_pkg::IDX_PROG) begin
        n.rsp.rdata[8:0] = {r.ch[2].st, r.ch[1].st, r.ch[0].st};
      end else if (idx == lse_pkg::IDX_PWM) begin
        n.rsp.rdata[23:0] = {r.ch[2].pwm, r.ch[1].pwm, r.ch[0].pwm};
      end else begin
        n.rsp.rresp = lse_pkg::RESP_SLVERR;
      end
    end
    n.rsp.arready = !n.rsp.rvalid;

    ////////////////////////////////////////////////////////////////////////
    // RQ18: per-channel engines, hardware wins over bus writes
    for (int c = 0; c < 3; c++) begin
      ins    = r.ch[c].ins;
      // RQ23: four-bit PC wraps 15 to 0
      seq_pc = (r.ch[c].run == lse_pkg::RUN_ONCE) ? r.ch[c].pc
                                                  : 4'(r.ch[c].pc + 4'h1);
      wm     = {ins[12], ins[9:7]};
      lc     = ins[12:7];
      done   = 1'b0;
      case (r.ch[c].st)
        lse_pkg::S_HOLD: begin
          if (n.ch[c].run != lse_pkg::RUN_HOLD) begin
            n.ch[c].st = lse_pkg::S_FHI;
          end
        end
        // RQ25: high byte first
        lse_pkg::S_FHI: begin
          n.ch[c].ins[15:8] = r.ch[c].mem[r.ch[c].pc][15:8];
          n.ch[c].st = lse_pkg::S_FLO;
        end
        lse_pkg::S_FLO: begin
          n.ch[c].ins[7:0] = r.ch[c].mem[r.ch[c].pc][7:0];
          n.ch[c].st = lse_pkg::S_EXE;
        end
        lse_pkg::S_EXE: begin
          n.ch[c].st  = lse_pkg::S_TIME;
          n.ch[c].cnt = lse_pkg::INSTR_TICKS;
          n.ch[c].pc  = seq_pc;
          if (!ins[15]) begin
            if (ins[13:8] == 6'h00) begin
              if (ins[14]) begin
                // RQ10: set PWM
                n.ch[c].pwm = ins[7:0];
              end else begin
                // RQ11: go to start
                n.ch[c].pc = 4'h0;
              end
            end else begin
              // RQ3: ramp decode
              // RQ5: step period
              n.ch[c].cnt   = step_period(ins);
              // RQ7: increment plus one
              n.ch[c].steps = 8'({1'b0, ins[6:0]} + 8'h01);
            end
          end else if (ins[14:13] == 2'h1) begin
            // RQ14: branch decode
            // RQ15: zero loops forever
            if (lc == 6'h00 || r.ch[c].lpc[r.ch[c].pc] < lc) begin
              // RQ13: jump to step number
              n.ch[c].pc = ins[3:0];
              if (lc != 6'h00) begin
                // RQ16: per-branch counter
                n.ch[c].lpc[r.ch[c].pc] =
                  6'(r.ch[c].lpc[r.ch[c].pc] + 6'h01);
              end
            end else begin
              // RQ24: reload on fall-through
              n.ch[c].lpc[r.ch[c].pc] = 6'h00;
            end
          end else if (ins[14:13] == 2'h2) begin
            // RQ17: end
            n.ch[c].pc  = 4'h0;
            n.ch[c].run = lse_pkg::RUN_HOLD;
            // RQ21: int and reset bits
            st_set[c] = ins[12];
            if (ins[11]) begin
              n.ch[c].pwm = 8'h00;
            end
          end
        end
        lse_pkg::S_TIME: begin
          if (tick) begin
            n.ch[c].cnt = 15'(r.ch[c].cnt - 15'h0001);
            if (r.ch[c].cnt <= 15'h0001) begin
              if (is_ramp(ins)) begin
                // RQ6: one count per step
                // RQ8: hold at the limits
                if (ins[6:0] != 7'h00) begin
                  if (!ins[7] && r.ch[c].pwm != 8'hFF) begin
                    n.ch[c].pwm = 8'(r.ch[c].pwm + 8'h01);
                  end else if (ins[7] && r.ch[c].pwm != 8'h00) begin
                    n.ch[c].pwm = 8'(r.ch[c].pwm - 8'h01);
                  end
                end
                n.ch[c].steps = 8'(r.ch[c].steps - 8'h01);
                n.ch[c].cnt   = step_period(ins);
                done = (r.ch[c].steps <= 8'h01);
              end else if (ins[15:13] == 3'h7) begin
                n.ch[c].st = lse_pkg::S_TWAIT;
              end else begin
                done = 1'b1;
              end
            end
          end
        end
        lse_pkg::S_TWAIT: begin
          // RQ22: stall until all masked triggers latched
          if ((r.ch[c].lat & wm) == wm) begin
            n.ch[c].lat = r.ch[c].lat & ~wm;
            done = 1'b1;
          end
        end
        default: n.ch[c].st = lse_pkg::S_HOLD;
      endcase
      // RQ22: latch incoming triggers, arrival beats the clear
      n.ch[c].lat = n.ch[c].lat |
                    {ext_evt, snd[2][c], snd[1][c], snd[0][c]};
      if (done) begin
        if (n.ch[c].run == lse_pkg::RUN_GO) begin
          n.ch[c].st = lse_pkg::S_FHI;
        end else begin
          n.ch[c].st  = lse_pkg::S_HOLD;
          n.ch[c].run = lse_pkg::RUN_HOLD;
        end
      end
    end

    // RQ21: set wins over read clear
    n.status   = (r.status & ~st_clr) | st_set;
    n.int_n    = !(|n.status);
    n.trig_oe  = (n.tout_cnt != 2'h0);
    n.trig_lvl = 1'b0;
    // RQ19: 8-bit PWM, 256 levels
    n.pcnt = 8'(r.pcnt + 8'h01);
    for (int c = 0; c < 3; c++) begin
      // RQ9: curve select
      n.duty[c]   = curve(r.ch[c].pwm, r.log_en);
      n.led_on[c] = (r.duty[c] > r.pcnt);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // RQ12: memory words clear to go-to-start
      r       <= '0;
      r.int_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign axi_rsp    = r.rsp;
  assign trig_out_n = r.trig_lvl;
  assign trig_oe    = r.trig_oe;
  assign int_n      = r.int_n;
  assign led_duty   = r.duty;
  assign led_on     = r.led_on;

  ////////////////////////////////////////////////////////////////////////////
  logic        c0_exe;
  logic [15:0] c0_word;
  assign c0_exe  = (r.ch[0].st == lse_pkg::S_EXE);
  assign c0_word = r.ch[0].mem[r.ch[0].pc];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_fetch;
    r.ch[0].st == lse_pkg::S_FHI ##1 r.ch[0].st == lse_pkg::S_FLO;
  endsequence
  sequence s_end_int;
    c0_exe && r.ch[0].ins[15:13] == 3'h6 && r.ch[0].ins[12];
  endsequence

  property p_fetch;
    s_fetch |=> c0_exe && r.ch[0].ins == c0_word;
  endproperty
  a_fetch: assert property (p_fetch) // RQ25
    else $error("fetched word differs from memory");

  property p_goto;
    (r.ch[1].st == lse_pkg::S_EXE && r.ch[1].ins == 16'h0000) |=>
      r.ch[1].pc == 4'h0 && r.ch[1].cnt == lse_pkg::INSTR_TICKS;
  endproperty
  a_goto: assert property (p_goto) // RQ11
    else $error("go to start did not reset PC");

  property p_setpwm;
    (c0_exe && r.ch[0].ins[15:8] == 8'h40) |=>
      r.ch[0].pwm == $past(r.ch[0].ins[7:0]);
  endproperty
  a_setpwm: assert property (p_setpwm) // RQ10
    else $error("set PWM value not loaded");

  property p_end;
    (c0_exe && r.ch[0].ins[15:13] == 3'h6) |=>
      r.ch[0].run == lse_pkg::RUN_HOLD && r.ch[0].pc == 4'h0;
  endproperty
  a_end: assert property (p_end) // RQ17
    else $error("end did not hold channel");

  property p_end_int;
    s_end_int |=> !int_n && r.status[0] ##1 r.status[0];
  endproperty
  a_end_int: assert property (p_end_int) // RQ21
    else $error("end interrupt not raised");

  property p_ramp;
    (r.ch[0].st == lse_pkg::S_TIME && !r.ch[0].ins[15]) |=>
      (r.ch[0].pwm == $past(r.ch[0].pwm)) ||
      (r.ch[0].pwm == 8'($past(r.ch[0].pwm) + 8'h01)) ||
      (r.ch[0].pwm == 8'($past(r.ch[0].pwm) - 8'h01));
  endproperty
  a_ramp: assert property (p_ramp) // RQ6
    else $error("ramp moved PWM by more than one");

  property p_branch;
    (r.ch[1].st == lse_pkg::S_EXE && r.ch[1].ins[15:13] == 3'h5 &&
     r.ch[1].ins[12:7] == 6'h00)
      |=> r.ch[1].pc == $past(r.ch[1].ins[3:0]);
  endproperty
  a_branch: assert property (p_branch) // RQ13
    else $error("infinite branch missed target");

  property p_tick;
    (r.tdiv == 12'h000) |=> r.tdiv == 12'(lse_pkg::TB_DIV - 12'h001);
  endproperty
  a_tick: assert property (p_tick) // RQ1
    else $error("base divider did not reload");

  property p_mem_reset;
    $rose(aresetn) |-> r.ch[0].mem == '0 && r.ch[2].mem == '0;
  endproperty
  a_mem_reset: assert property (p_mem_reset) // RQ12
    else $error("program memory not cleared");
endmodule : lse_engine

// >>> sim/lse_far_side.sv
// Far-side model: external base clock source and pulled-up trigger line
`timescale 1ns/1ps
module lse_far_side #(
  parameter int HALF = 8
) (
  input  wire logic aclk,
  input  wire logic trig_out_n,
  input  wire logic trig_oe,
  output logic      ext_timebase_input,
  output logic      trig_in_n
);
  int unsigned div_r;

  initial begin
    ext_timebase_input = 1'b0;
    div_r = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // base clock source
  // Runs far faster than the real part so a program fits in a short run
  always @(posedge aclk) begin
    div_r <= (div_r == HALF - 1) ? 0 : div_r + 1;
    if (div_r == HALF - 1) begin
      ext_timebase_input <= ~ext_timebase_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain trigger line
  // Pull-up keeps the line high whenever nobody pulls it down
  assign trig_in_n = trig_oe ? trig_out_n : 1'b1;
endmodule : lse_far_side

// >>> sim/led_sequence_engine_test.sv
// Self-checking bench for the LED sequence engine over AXI4-Lite
`timescale 1ns/1ps
module led_sequence_engine_test;
  logic                  aclk;
  logic                  aresetn;
  lse_pkg::lse_axi_req_t req;
  lse_pkg::lse_axi_rsp_t rsp;
  logic                  ext_tb;
  logic                  trig_in_n;
  logic                  trig_out_n;
  logic                  trig_oe;
  logic                  int_n;
  logic [2:0][7:0]       led_duty;
  logic [2:0]            led_on;
  int                    n_mismatch = 0;
  int                    n_checks = 0;
  int                    cyc = 0;
  int                    n_trig = 0;
  logic                  oe_d = 1'b0;
  logic [31:0]           rdat;
  logic [1:0]            resp;
  int                    t;
  logic [15:0]           prog [6] = '{16'h40FA, 16'h0109, 16'h0181,
                                      16'hA102, 16'hE040, 16'hD000};

  lse_engine dut (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .axi_req            (req),
    .axi_rsp            (rsp),
    .ext_timebase_input (ext_tb),
    .trig_in_n          (trig_in_n),
    .trig_out_n         (trig_out_n),
    .trig_oe            (trig_oe),
    .int_n              (int_n),
    .led_duty           (led_duty),
    .led_on             (led_on)
  );

  lse_far_side far (
    .aclk               (aclk),
    .trig_out_n         (trig_out_n),
    .trig_oe            (trig_oe),
    .ext_timebase_input (ext_tb),
    .trig_in_n          (trig_in_n)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // Called just after a rising edge; bready stays high for the whole run
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    req.awaddr <= {idx, 2'b00};
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_d && rsp.awready) begin
        aw_d = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_d && rsp.wready) begin
        w_d = 1'b1;
        req.wvalid <= 1'b0;
      end
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    logic ar_d;
    ar_d = 1'b0;
    req.araddr <= {idx, 2'b00};
    req.arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ar_d && rsp.arready) begin
        ar_d = 1'b1;
        req.arvalid <= 1'b0;
      end
    end while (rsp.rvalid !== 1'b1);
    rdat = rsp.rdata;
    resp = rsp.rresp;
  endtask : rd

  task automatic rc(input logic [7:0] idx, input logic [31:0] m,
                    input logic [31:0] exp, input string nm);
    rd(idx);
    chk(nm, rdat & m, exp);
  endtask : rc

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard; the full sequence needs about 7000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  always @(posedge aclk) begin
    oe_d <= trig_oe;
    if (trig_oe === 1'b1 && oe_d === 1'b0) begin
      n_trig <= n_trig + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    @(posedge aclk);
    chk("int_n after reset", {31'h0, int_n}, 32'h1);
    rc(lse_pkg::IDX_ENABLE, 32'hFF, 32'h0, "enable reset");
    rc(lse_pkg::IDX_STATUS, 32'h7, 32'h0, "status reset");
    rc(lse_pkg::IDX_PWM, 32'hFFFFFF, 32'h0, "pwm reset");
    rd(8'h05);
    chk("rresp unmapped", 32'(resp), 32'(lse_pkg::RESP_SLVERR));
    wr(8'h05, 32'h1);
    chk("bresp unmapped", 32'(resp), 32'(lse_pkg::RESP_SLVERR));
    wr(lse_pkg::IDX_CONFIG, 32'h2);
    chk("bresp config", 32'(resp), 32'(lse_pkg::RESP_OKAY));
    for (int i = 0; i < 6; i++) begin
      wr(lse_pkg::IDX_PROG, {12'h000, 4'(i), prog[i]});
    end
    // Saturating ramp, looped ramp-down, external trigger, end with int
    wr(lse_pkg::IDX_ENABLE, 32'h20);
    t = 0;
    while (int_n !== 1'b0 && t < 20000) begin
      @(posedge aclk);
      t++;
    end
    chk("run cycles", {31'h0, t >= 5200 && t <= 6400}, 32'h1);
    chk("int_n at end", {31'h0, int_n}, 32'h0);
    chk("trigger pulses", n_trig, 32'h1);
    chk("trig_out_n level", {31'h0, trig_out_n}, 32'h0);
    rc(lse_pkg::IDX_STATUS, 32'h7, 32'h1, "status end");
    repeat (3) @(posedge aclk);
    chk("int_n cleared", {31'h0, int_n}, 32'h1);
    rc(lse_pkg::IDX_STATUS, 32'h7, 32'h0, "status cleared");
    rc(lse_pkg::IDX_ENABLE, 32'hFF, 32'h0, "run field hold");
    rc(lse_pkg::IDX_PC0, 32'hF, 32'h0, "pc after end");
    rc(lse_pkg::IDX_PWM, 32'hFF, 32'd249, "pwm result");
    chk("duty linear", 32'(led_duty[0]), 32'd249);
    wr(lse_pkg::IDX_ENABLE, 32'h80);
    repeat (4) @(posedge aclk);
    chk("duty log", 32'(led_duty[0]), 32'((249 * 249 + 255) >> 8));
    // Free counter sweeps all 256 levels, so high count equals the duty
    t = 0;
    repeat (256) begin
      @(posedge aclk);
      t += led_on[0];
    end
    chk("led_on high count", t, 32'd243);
    // Unwritten memory runs as jump to 0; green 5 loops there forever
    wr(lse_pkg::IDX_PROG, {12'h001, 4'h5, 16'hA000});
    wr(lse_pkg::IDX_PC0 + 8'h01, 32'h5);
    rc(lse_pkg::IDX_PC0 + 8'h01, 32'hF, 32'h5, "green pc load");
    wr(lse_pkg::IDX_ENABLE, 32'h88);
    repeat (300) @(posedge aclk);
    wr(lse_pkg::IDX_ENABLE, 32'h80);
    repeat (800) @(posedge aclk);
    rc(lse_pkg::IDX_PC0 + 8'h01, 32'hF, 32'h0, "green pc");
    rc(lse_pkg::IDX_PWM, 32'hFF00, 32'h0, "green pwm");
    print_verdict();
  end
endmodule : led_sequence_engine_test
